// ===== sdc_core.sv
`timescale 1ns/1ns
module sdc_core #(
   parameter int unsigned TOGGLE_CYC = sdc_pkg::SSC_TOGGLE_CYC,
   parameter int unsigned PRE_DIV = sdc_pkg::REF_PRE_DIV
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oen,
   input wire logic addr_sel,
   input wire logic parallel_latch_strobe_low,
   input wire logic [8:0] feedback_divide_bits,
   input wire logic [1:0] output_divide_select,
   output logic [8:0] feedback_divide_value,
   output logic [9:0] loop_multiplier,
   output logic pfd_ref_strobe,
   output logic spread_active,
   output logic primary_clock_output,
   output logic secondary_clock_output
);
   import sdc_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Divider value offset by the step, kept at nine bits
   function automatic logic [8:0] fb_offset(input logic [8:0] base,
                                            input logic [5:0] step,
                                            input logic up);
      logic [9:0] sum;
      sum = '0;
      if (up) begin
         sum = {1'b0, base} + {4'h0, step};
      end else begin
         sum = {1'b0, base} - {4'h0, step};
      end
      fb_offset = sum[8:0];
   endfunction
   // Output ratio for one output from the select code
   function automatic logic [2:0] div_ratio(input logic [1:0] sel,
                                            input logic second);
      case (sel)
         2'b00: div_ratio = second ? DIV_B_00 : DIV_A_00;
         2'b01: div_ratio = second ? DIV_B_01 : DIV_A_01;
         2'b10: div_ratio = second ? DIV_B_10 : DIV_A_10;
         default: div_ratio = second ? DIV_B_11 : DIV_A_11;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   initial begin
      if (TOGGLE_CYC < 2 || TOGGLE_CYC > 4096) begin
         $error("sdc_core: TOGGLE_CYC out of range");
      end
      if (PRE_DIV < 2 || PRE_DIV > 256) begin
         $error("sdc_core: PRE_DIV out of range");
      end
   end

   // ----------------------------------------------------------------
   // Serial line edge detection
   // ----------------------------------------------------------------
   logic scl_prev_r, sda_prev_r;
   logic scl_rise, scl_fall, start_det, stop_det;
   // Previous pin levels; pins are synchronous to clk
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_prev_r <= scl_i;
         sda_prev_r <= sda_i;
      end
   end

   // Bus events
   assign scl_rise = scl_i && !scl_prev_r;
   assign scl_fall = !scl_i && scl_prev_r;
   assign start_det = scl_i && scl_prev_r && sda_prev_r && !sda_i;
   assign stop_det = scl_i && scl_prev_r && !sda_prev_r && sda_i;

   // ----------------------------------------------------------------
   // Serial receive state machine
   // ----------------------------------------------------------------
   sdc_i2c_e state_r, state_nxt;
   logic [2:0] bit_cnt_r, byte_cnt_r;
   logic [7:0] shift_r, rx_byte;
   logic want_ack_r, ack_drive_r;
   sdc_cfg_s stage_r;
   logic commit, shifting, last_bit, addr_hit, buf_full;
   logic [6:0] own_addr;
   // Received byte, address match and fill level
   assign shifting = (state_r == ST_ADDR) || (state_r == ST_DATA);
   assign last_bit = shifting && scl_rise && (bit_cnt_r == BIT_LAST);
   assign rx_byte = {shift_r[6:0], sda_i};
   assign own_addr = ADDR7_BASE | (7'(addr_sel) << ADDR7_SEL_POS);
   assign addr_hit = (rx_byte[7:1] == own_addr) && !rx_byte[0];
   assign buf_full = (byte_cnt_r == DATA_BYTES);
   assign commit = stop_det && buf_full && (state_r != ST_IDLE);

   // Next state; start and stop take precedence over bit traffic
   always_comb begin
      state_nxt = state_r;
      if (start_det) begin
         state_nxt = ST_ADDR;
      end else if (stop_det) begin
         state_nxt = ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_ADDR, ST_DATA: begin
               if (last_bit) begin
                  state_nxt = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (scl_fall) begin
                  state_nxt = want_ack_r ? ST_ACK : ST_SKIP;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_nxt = buf_full ? ST_SKIP : ST_DATA;
               end
            end
            ST_SKIP: state_nxt = ST_SKIP;
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bit counter and shift register; idle in skip state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_r <= '0;
         shift_r <= '0;
      end else if (start_det || state_r == ST_ACK) begin
         bit_cnt_r <= '0;
      end else if (shifting && scl_rise) begin
         bit_cnt_r <= bit_cnt_r + 1'b1;
         shift_r <= rx_byte;
      end
   end

   // Byte count and acknowledge decision at the eighth bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         byte_cnt_r <= '0;
         want_ack_r <= 1'b0;
      end else if (start_det) begin
         byte_cnt_r <= '0;
         want_ack_r <= 1'b0;
      end else if (last_bit && state_r == ST_ADDR) begin
         want_ack_r <= addr_hit;
      end else if (last_bit) begin
         byte_cnt_r <= byte_cnt_r + 1'b1;
         want_ack_r <= 1'b1;
      end
   end

   // Data bytes land in the staging copy; the byte at count 0 is the dummy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage_r <= CFG_RST;
      end else if (last_bit && state_r == ST_DATA) begin
         case (byte_cnt_r)
            IDX_BYTE0: begin
               stage_r.osel <= rx_byte[B0_OSEL_LSB+1:B0_OSEL_LSB];
               stage_r.fb_div[8:3] <= rx_byte[B0_FB_MSB:0];
            end
            IDX_BYTE1: begin
               stage_r.fb_div[2:0] <= rx_byte[7:B1_FB_LSB];
            end
            IDX_BYTE2: begin
               stage_r.upper_spread_enable <= rx_byte[B2_UP_POS];
               stage_r.lower_spread_enable <= rx_byte[B2_LOW_POS];
               stage_r.step <= rx_byte[B2_STEP_MSB:0];
            end
            default: stage_r <= stage_r;
         endcase
      end
   end

   // Acknowledge driven from the fall after bit 8 to the next fall
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_drive_r <= 1'b0;
      end else if (start_det || stop_det) begin
         ack_drive_r <= 1'b0;
      end else if (scl_fall) begin
         ack_drive_r <= (state_r == ST_WAIT) && want_ack_r;
      end
   end

   // Data line is open drain and only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oen = !ack_drive_r;

   // ----------------------------------------------------------------
   // Held configuration and mode selection
   // ----------------------------------------------------------------
   logic strobe_prev_r, strobe_rise, spread_on;
   sdc_cfg_s cfg_r;
   logic [8:0] fb_sel;
   logic [1:0] osel_sel;
   assign strobe_rise = parallel_latch_strobe_low && !strobe_prev_r;
   // Previous strobe level; starts at the pulled-up idle level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_prev_r <= 1'b1; // No false rise right after reset
      end else begin
         strobe_prev_r <= parallel_latch_strobe_low;
      end
   end

   // Serial commit replaces all fields; strobe rise captures the pins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= CFG_RST;
      end else if (commit) begin
         cfg_r <= stage_r;
      end else if (strobe_rise) begin
         cfg_r.fb_div <= feedback_divide_bits;
         cfg_r.osel <= output_divide_select;
      end
   end

   // Pins pass straight through while the strobe is low
   assign fb_sel = parallel_latch_strobe_low ? cfg_r.fb_div :
                   feedback_divide_bits;
   assign osel_sel = parallel_latch_strobe_low ? cfg_r.osel :
                     output_divide_select;
   assign spread_on = parallel_latch_strobe_low &&
      (cfg_r.upper_spread_enable || cfg_r.lower_spread_enable);

   // ----------------------------------------------------------------
   // Modulation timing and reference pre-divider
   // ----------------------------------------------------------------
   logic [11:0] tog_cnt_r;
   logic [7:0] ref_cnt_r;
   logic phase_r, ref_end;
   assign ref_end = (ref_cnt_r == 8'(PRE_DIV - 1));
   // Modulation phase flips every TOGGLE_CYC clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tog_cnt_r <= '0;
         phase_r <= 1'b0;
      end else if (tog_cnt_r == 12'(TOGGLE_CYC - 1)) begin
         tog_cnt_r <= '0;
         phase_r <= ~phase_r;
      end else begin
         tog_cnt_r <= tog_cnt_r + 1'b1;
      end
   end

   // Reference divided before the phase comparison
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_r <= '0;
      end else if (ref_end) begin
         ref_cnt_r <= '0;
      end else begin
         ref_cnt_r <= ref_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Spread target and feedback divider update
   // ----------------------------------------------------------------
   logic [8:0] fb_plus, fb_minus, fb_target, fb_r;
   logic [9:0] mult_r;
   logic pfd_r;
   assign fb_plus = fb_offset(fb_sel, cfg_r.step, 1'b1);
   assign fb_minus = fb_offset(fb_sel, cfg_r.step, 1'b0);
   // Target value for the current modulation phase
   always_comb begin
      fb_target = fb_sel;
      if (spread_on) begin
         case ({cfg_r.upper_spread_enable, cfg_r.lower_spread_enable})
            2'b10: fb_target = phase_r ? fb_plus : fb_sel;
            2'b01: fb_target = phase_r ? fb_minus : fb_sel;
            2'b11: fb_target = phase_r ? fb_plus : fb_minus;
            default: fb_target = fb_sel;
         endcase
      end
   end

   // Divider value changes only at a divided-reference boundary
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fb_r <= FB_RST;
         mult_r <= {FB_RST, 1'b0};
         pfd_r <= 1'b0;
      end else begin
         pfd_r <= ref_end;
         if (ref_end) begin
            fb_r <= fb_target;
            mult_r <= {fb_target, 1'b0};
         end
      end
   end

   assign feedback_divide_value = fb_r;
   assign loop_multiplier = mult_r;
   assign pfd_ref_strobe = pfd_r;
   assign spread_active = spread_on;

   // ----------------------------------------------------------------
   // Output dividers
   // ----------------------------------------------------------------
   logic [2:0] ratio_a, ratio_b;
   assign ratio_a = div_ratio(osel_sel, 1'b0);
   assign ratio_b = div_ratio(osel_sel, 1'b1);
   // Primary output divider
   sdc_out_div #(.W(3)) u_div_a (
      .clk(clk),
      .rstn(rstn),
      .ratio(ratio_a),
      .clk_out(primary_clock_output)
   );

   // Secondary output divider
   sdc_out_div #(.W(3)) u_div_b (
      .clk(clk),
      .rstn(rstn),
      .ratio(ratio_b),
      .clk_out(secondary_clock_output)
   );

endmodule

// ===== sdc_pkg.sv
package sdc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SSC_RATE_HZ = 32_000;
   // Clock cycles between modulation toggles (longest time, rounded down)
   localparam int unsigned SSC_TOGGLE_CYC = CLK_HZ / SSC_RATE_HZ;
   localparam int unsigned REF_PRE_DIV = 16;

   // ----------------------------------------------------------------
   // Serial port addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR7_BASE = 7'h6c;
   localparam int unsigned ADDR7_SEL_POS = 1;
   localparam logic [2:0] DATA_BYTES = 3'h4;
   localparam logic [2:0] IDX_BYTE0 = 3'h1;
   localparam logic [2:0] IDX_BYTE1 = 3'h2;
   localparam logic [2:0] IDX_BYTE2 = 3'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned B0_OSEL_LSB = 6;
   localparam int unsigned B0_FB_MSB = 5;
   localparam int unsigned B1_FB_LSB = 5;
   localparam int unsigned B2_UP_POS = 7;
   localparam int unsigned B2_LOW_POS = 6;
   localparam int unsigned B2_STEP_MSB = 5;
   localparam logic [8:0] FB_RST = 9'h100;
   localparam logic [1:0] OSEL_RST = 2'h0;
   localparam logic [5:0] STEP_RST = 6'h00;
   localparam logic [7:0] BYTE0_RST = 8'h20;
   localparam logic [7:0] BYTE2_RST = 8'h00;

   // ----------------------------------------------------------------
   // Output divide ratios per select code
   // ----------------------------------------------------------------
   localparam logic [2:0] DIV_A_00 = 3'h2;
   localparam logic [2:0] DIV_B_00 = 3'h4;
   localparam logic [2:0] DIV_A_01 = 3'h1;
   localparam logic [2:0] DIV_B_01 = 3'h2;
   localparam logic [2:0] DIV_A_10 = 3'h2;
   localparam logic [2:0] DIV_B_10 = 3'h6;
   localparam logic [2:0] DIV_A_11 = 3'h1;
   localparam logic [2:0] DIV_B_11 = 3'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] osel;
      logic [8:0] fb_div;
      logic upper_spread_enable;
      logic lower_spread_enable;
      logic [5:0] step;
   } sdc_cfg_s;

   localparam sdc_cfg_s CFG_RST = '{osel: OSEL_RST, fb_div: FB_RST,
      upper_spread_enable: 1'b0, lower_spread_enable: 1'b0,
      step: STEP_RST};

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_ADDR = 6'b00_0010,
      ST_WAIT = 6'b00_0100,
      ST_ACK = 6'b00_1000,
      ST_DATA = 6'b01_0000,
      ST_SKIP = 6'b10_0000
   } sdc_i2c_e;

endpackage

// ===== sdc_out_div.sv
`timescale 1ns/1ns
module sdc_out_div #(
   parameter int unsigned W = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] ratio,
   output logic clk_out
);
   import sdc_pkg::*;

   // ----------------------------------------------------------------
   // Half-period divider: each clk edge is one half VCO period
   // ----------------------------------------------------------------
   logic [W-1:0] cnt_r;
   logic [W-1:0] ratio_r;
   logic level_r;
   logic half_end;
   logic period_end;

   initial begin
      if (W < 2) begin
         $error("sdc_out_div: W must be at least 2");
      end
   end

   // Half period ends after ratio ticks; period ends at high-to-low
   assign half_end = (cnt_r >= ratio_r - 1'b1) || (ratio_r == '0);
   assign period_end = half_end && level_r;

   // High and low halves both last ratio ticks, even for odd ratios
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
         level_r <= 1'b0;
         ratio_r <= W'(1);
      end else if (half_end) begin
         cnt_r <= '0;
         level_r <= ~level_r;
         if (period_end) begin
            ratio_r <= ratio; // New ratio only at a period boundary
         end
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign clk_out = level_r;

endmodule

// ===== sdc_core_sva.sv
`timescale 1ns/1ns
module sdc_core_sva #(
   parameter int unsigned TOGGLE_CYC = 625,
   parameter int unsigned PRE_DIV = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oen,
   input wire logic addr_sel,
   input wire logic parallel_latch_strobe_low,
   input wire logic [8:0] feedback_divide_bits,
   input wire logic [1:0] output_divide_select,
   input wire logic [8:0] feedback_divide_value,
   input wire logic [9:0] loop_multiplier,
   input wire logic pfd_ref_strobe,
   input wire logic spread_active,
   input wire logic primary_clock_output,
   input wire logic secondary_clock_output
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // Shared sequences
   // ----------------------------------------------------------------
   // One clock after a sampled serial clock fall
   sequence s_after_scl_fall;
      !$past(scl_i) && $past(scl_i, 2);
   endsequence
   // Parallel pins steady with the strobe low
   sequence s_pins_held;
      (!parallel_latch_strobe_low && $stable(feedback_divide_bits))[*3];
   endsequence

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reset_values: assert property ($rose(rstn) |-> sda_oen &&
      feedback_divide_value == 9'h100 && !pfd_ref_strobe &&
      !primary_clock_output && !secondary_clock_output)
      else $error("values after reset wrong");
   a_mult_double: assert property (
      loop_multiplier == {feedback_divide_value, 1'b0})
      else $error("loop multiplier not twice divider");
   a_pfd_period: assert property (pfd_ref_strobe |=>
      !pfd_ref_strobe [*8] ##1 !pfd_ref_strobe [*7] ##1 pfd_ref_strobe)
      else $error("reference strobe period wrong");
   a_fb_boundary: assert property (
      $changed(feedback_divide_value) |-> pfd_ref_strobe)
      else $error("divider changed off boundary");
   a_spread_off: assert property (
      !parallel_latch_strobe_low |-> !spread_active)
      else $error("spread active with strobe low");
   a_sda_pull_only: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   a_ack_start: assert property ($fell(sda_oen) |-> s_after_scl_fall)
      else $error("acknowledge begins at wrong time");
   a_ack_end: assert property ($rose(sda_oen) |-> s_after_scl_fall)
      else $error("acknowledge ends at wrong time");
   a_oen_steady: assert property (
      scl_i && $past(scl_i) |-> $stable(sda_oen))
      else $error("data enable moved with clock high");
   a_parallel_pass: assert property (s_pins_held ##0 pfd_ref_strobe
      |-> feedback_divide_value == feedback_divide_bits)
      else $error("divider does not follow pins");
endmodule

bind sdc_core sdc_core_sva #(.TOGGLE_CYC(TOGGLE_CYC), .PRE_DIV(PRE_DIV))
   u_sdc_core_sva (.clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oen(sda_oen), .addr_sel(addr_sel),
   .parallel_latch_strobe_low(parallel_latch_strobe_low),
   .feedback_divide_bits(feedback_divide_bits),
   .output_divide_select(output_divide_select),
   .feedback_divide_value(feedback_divide_value),
   .loop_multiplier(loop_multiplier), .pfd_ref_strobe(pfd_ref_strobe),
   .spread_active(spread_active),
   .primary_clock_output(primary_clock_output),
   .secondary_clock_output(secondary_clock_output));

// ===== sdc_i2c_master.sv
`timescale 1ns/1ns
module sdc_i2c_master (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low,
   output logic ack_vld,
   output logic ack_bit
);
   // Idle bus: clock high and still, data released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      ack_vld = 1'b0;
      ack_bit = 1'b0;
   end

   // ----------------------------------------------------------------
   // Bus conditions
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic start_cond;
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop_cond;
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask
   // Byte out, most significant bit first, then ninth clock
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_low <= !b[i];
         tick(2);
         scl <= 1'b1;
         tick(4);
         scl <= 1'b0;
         tick(2);
      end
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(2);
      ack_bit <= !sda_in;
      ack_vld <= 1'b1;
      tick(1);
      ack_vld <= 1'b0;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask
endmodule

// ===== test_synth_divider_ssc_control.sv
`timescale 1ns/1ns
module test_synth_divider_ssc_control;
   import sdc_pkg::*;
   logic clk, rstn, addr_sel, par_strobe_low, scl, sda_low, sda_o, sda_oen;
   logic ack_vld, ack_bit, win_on, w_prev;
   logic [8:0] fb_pins, fb_val, m, m2, lo, hi, lo_s, hi_s;
   logic [1:0] osel_pins;
   logic [5:0] s;
   logic [17:0] note;
   logic ack_q[$];
   logic [17:0] fb_q[$];
   logic [5:0] steps [4] = '{6'h01, 6'h04, 6'h06, 6'h08};
   int err_count, n_compared;
   int run0, run1;
   logic q0, q1, q0_p, q1_p;
   logic [2:0] div_a [4] = '{3'h2, 3'h1, 3'h2, 3'h1};
   logic [2:0] div_b [4] = '{3'h4, 3'h2, 3'h6, 3'h3};
   wire sda_bus = !sda_low && (sda_oen || sda_o);

   sdc_core #(.TOGGLE_CYC(20)) u_sdc_core (.clk(clk), .rstn(rstn),
      .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oen(sda_oen),
      .addr_sel(addr_sel), .parallel_latch_strobe_low(par_strobe_low),
      .feedback_divide_bits(fb_pins), .output_divide_select(osel_pins),
      .feedback_divide_value(fb_val), .loop_multiplier(),
      .pfd_ref_strobe(), .spread_active(), .primary_clock_output(q0),
      .secondary_clock_output(q1));
   sdc_i2c_master u_sdc_i2c_master (.clk(clk), .sda_in(sda_bus),
      .scl(scl), .sda_low(sda_low), .ack_vld(ack_vld), .ack_bit(ack_bit));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Compare and verdict
   // ----------------------------------------------------------------
   task cmp_fb(input string what, input logic [8:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task cmp_ack(input logic exp, got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch ack expected %b seen %b", exp, got);
      end
   endtask
   task cmp_half(input string what, input logic [2:0] exp,
      input logic [3:0] got);
      n_compared++;
      if (got !== {1'b0, exp}) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task finish_test;
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   // Settle, then note the divider range seen over a window
   task expect_fb(input logic [8:0] l, h, input int n);
      repeat (40) @(posedge clk);
      fb_q.push_back({l, h});
      win_on <= 1'b1;
      repeat (n) @(posedge clk);
      win_on <= 1'b0;
      @(posedge clk);
   endtask
   // Address, then the first nd of: dummy, three data bytes, extra; then stop
   task automatic write_cfg(input logic [6:0] a7, input logic [8:0] v,
      input logic [7:0] b2, input int nd, input logic ok);
      logic [7:0] by [5];
      by = '{8'h5a, {2'($urandom), v[8:3]}, {v[2:0], 5'h15}, b2, 8'hff};
      u_sdc_i2c_master.start_cond();
      ack_q.push_back(ok);
      u_sdc_i2c_master.send_byte({a7, 1'b0});
      for (int k = 0; k < nd; k++) begin
         ack_q.push_back(ok && k < 4);
         u_sdc_i2c_master.send_byte(by[k]);
      end
      u_sdc_i2c_master.stop_cond();
   endtask

   // Output watcher: divider range per window, ack per ninth clock
   always @(posedge clk) begin
      if (win_on && !w_prev) begin
         lo_s = fb_val;
         hi_s = fb_val;
      end else if (win_on) begin
         if (fb_val < lo_s) lo_s = fb_val;
         if (fb_val > hi_s) hi_s = fb_val;
      end else if (w_prev) begin
         note = fb_q.pop_front();
         cmp_fb("divider low", note[17:9], lo_s);
         cmp_fb("divider high", note[8:0], hi_s);
      end
      w_prev = win_on;
      if (ack_vld) cmp_ack(ack_q.pop_front(), ack_bit);
   end

   // Half periods of both outputs while the pins pick the ratios
   always @(posedge clk) begin
      if (win_on && !par_strobe_low) begin
         if (q0 !== q0_p && run0 > 0) begin
            cmp_half("pri half", div_a[osel_pins], 4'(run0));
         end
         if (q1 !== q1_p && run1 > 0) begin
            cmp_half("sec half", div_b[osel_pins], 4'(run1));
         end
         run0 = (q0 !== q0_p) ? 1 : ((run0 > 0) ? run0 + 1 : 0);
         run1 = (q1 !== q1_p) ? 1 : ((run1 > 0) ? run1 + 1 : 0);
      end else begin
         run0 = 0;
         run1 = 0;
      end
      q0_p = q0;
      q1_p = q1;
   end

   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(52));
      rstn = 1'b0;
      addr_sel = 1'b0;
      par_strobe_low = 1'b1;
      fb_pins = 9'h000;
      osel_pins = 2'h0;
      win_on = 1'b0;
      w_prev = 1'b0;
      err_count = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      expect_fb(9'h100, 9'h100, 20);
      m = 9'(120 + $urandom_range(216));
      par_strobe_low <= 1'b0;
      fb_pins <= m;
      osel_pins <= 2'($urandom);
      expect_fb(m, m, 40);
      par_strobe_low <= 1'b1;
      @(posedge clk);
      fb_pins <= ~m;
      expect_fb(m, m, 40);
      m2 = 9'(120 + $urandom_range(216));
      write_cfg(7'h6c, m2, 8'h00, 5, 1'b1);
      expect_fb(m2, m2, 40);
      write_cfg(7'h6e, 9'h0f0, 8'h00, 4, 1'b0);
      expect_fb(m2, m2, 40);
      addr_sel <= 1'b1;
      write_cfg(7'h6e, 9'h0f0, 8'h00, 2, 1'b1);
      expect_fb(m2, m2, 40);
      for (int md = 1; md < 4; md++) begin
         s = steps[$urandom_range(3)];
         m = 9'(120 + $urandom_range(200));
         write_cfg(7'h6e, m, {2'(md), s}, 4, 1'b1);
         lo = (md == 2) ? m : m - 9'(s);
         hi = (md == 1) ? m : m + 9'(s);
         expect_fb(lo, hi, 200);
      end
      m = 9'(120 + $urandom_range(216));
      fb_pins <= m;
      osel_pins <= 2'($urandom);
      par_strobe_low <= 1'b0;
      expect_fb(m, m, 60);
      finish_test();
   end
endmodule
